/* File: dv/ramp_status_flags_assertions.sv */
// Port checker of the ramp status flags block
`timescale 1ns/1ps
`default_nettype none
module ramp_status_flags_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic stall_input_active,
    input wire logic stall_halt_request,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic odd;
    // Unmapped: outside the five words or misaligned
    assign odd = paddr < 12'h180 || paddr > 12'h190 || paddr[1:0] != 2'b00;
    property p_wait; psel && penable && !pready |=> pready; endproperty
    a_wait: assert property (p_wait) else $error("ready not one cycle late");
    property p_ready; pready |-> psel && penable; endproperty
    a_ready: assert property (p_ready) else $error("ready outside access");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than one");
    property p_err; pready |-> pslverr == odd; endproperty
    a_err: assert property (p_err) else $error("error flag wrong");
    property p_lone; pslverr |-> pready; endproperty
    a_lone: assert property (p_lone) else $error("error without ready");
    property p_hold; !pready |-> $stable(prdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_set; $rose(stall_halt_request) |-> $past(stall_input_active);
    endproperty
    a_set: assert property (p_set) else $error("halt without stall");
    // Only a bus write may take the halt request away
    property p_clr; $fell(stall_halt_request) |-> $past(pready && pwrite);
    endproperty
    a_clr: assert property (p_clr) else $error("halt dropped alone");
endmodule // ramp_status_flags_checker
////////////////////////////////////////////////////////////////////////////
bind ramp_status_flags ramp_status_flags_checker u_chk (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .stall_input_active, .stall_halt_request, .irq);
`default_nettype wire

/* File: dv/ramp_status_flags_tb_top.sv */
// Self-checking bench of the ramp status flags block
`timescale 1ns/1ps
`default_nettype none
`include "ramp_status_regs.vh"
module ramp_status_flags_tb_top;
    localparam [11:0] ST = `OFS_RAMP_STATUS;
    localparam [11:0] CT = `OFS_CONTROL;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [11:0] paddr, ctl;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [31:0] current_position, target_position;
    logic [31:0] current_velocity, max_velocity;
    logic stall_input_active, direction_reversed, post_halt_wait_active;
    logic ref_switch_r, ref_switch_l, virtual_stop_r, virtual_stop_l;
    logic moving_positive, moving_negative, motor_at_rest;
    logic stall_halt_request, stop_r_request, stop_l_request;
    integer miscompares, total_checks, seed, i;
    logic [3:0] outs;
    // Outputs by index so a check can look at them after waiting
    assign outs = {stop_l_request, stop_r_request, stall_halt_request, irq};
    ramp_status_flags DUT (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .current_position, .target_position, .current_velocity,
        .max_velocity, .stall_input_active, .direction_reversed,
        .post_halt_wait_active, .ref_switch_r, .ref_switch_l,
        .virtual_stop_r, .virtual_stop_l, .moving_positive,
        .moving_negative, .motor_at_rest, .stall_halt_request,
        .stop_r_request, .stop_l_request, .irq);
    ////////////////////////////////////////////////////////////////////////
    // 8 ns clock and a watchdog far beyond the run
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        miscompares = miscompares + 1;
        conclude;
    end
    task conclude;
        if (miscompares == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] e, input logic [31:0] g);
        total_checks = total_checks + 1;
        if (g !== e)
        begin
            miscompares = miscompares + 1;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    // One APB transfer; ready is sampled before the edge updates land
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task sb(input string what, input integer b, input logic e);
        apb(1'b0, ST, 32'h0, 4'hF);
        chk(what, {31'h0, e}, {31'h0, rd[b]});
    endtask
    task pin(input string what, input logic e, input integer w);
        repeat (2) @(posedge pclk);
        chk(what, {31'h0, e}, {31'h0, outs[w]});
    endtask
    // Level bits expected from the inputs now applied
    function automatic logic [31:0] live();
        live = {16'h0, virtual_stop_r, virtual_stop_l,
            stall_input_active & ctl[0], 1'b0, post_halt_wait_active,
            current_velocity == 0, current_position == target_position,
            current_velocity == max_velocity, 6'h0,
            ref_switch_r ^ ctl[8], ref_switch_l ^ ctl[9]};
    endfunction
    initial
    begin
        seed = 32'hBDE6;
        miscompares = 0;
        total_checks = 0;
        {psel, penable, pwrite, paddr, pwdata, pstrb, ctl} = '0;
        {stall_input_active, direction_reversed, post_halt_wait_active} = '0;
        {ref_switch_r, ref_switch_l, virtual_stop_r, virtual_stop_l} = '0;
        {moving_positive, moving_negative, motor_at_rest} = '0;
        {current_position, target_position} = {32'h0, 32'h5};
        {current_velocity, max_velocity} = {32'h7, 32'h9};
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `OFS_IRQ_MASK, 32'h0, 4'hF);
        chk("mask", 32'hF, rd);
        apb(1'b0, ST, 32'h0, 4'hF);
        chk("status", 32'h0, rd);
        apb(1'b0, 12'h1FC, 32'h0, 4'hF);
        chk("unmapped", 32'h1, {rd[30:0], err});
        // Random levels, small ranges so that matches occur often
        for (i = 0; i < 24; i = i + 1)
        begin
            ctl = 12'h301 & 12'($random(seed));
            apb(1'b1, CT, {20'h0, ctl}, 4'hF);
            current_position <= 32'($random(seed)) & 32'h3;
            target_position <= 32'($random(seed)) & 32'h3;
            current_velocity <= 32'($random(seed)) & 32'h3;
            max_velocity <= 32'($random(seed)) & 32'h3;
            {stall_input_active, post_halt_wait_active, ref_switch_r,
                ref_switch_l, virtual_stop_r} <= 5'($random(seed));
            repeat (5) @(posedge pclk);
            apb(1'b0, ST, 32'h0, 4'hF);
            chk("live", live() & 32'hEF03, rd & 32'hEF03);
        end
        {target_position, stall_input_active, ref_switch_r} <= '1;
        {current_position, ref_switch_l, virtual_stop_r} <= '0;
        apb(1'b1, CT, 32'h0, 4'hF);
        apb(1'b1, `OFS_IRQ_MASK, 32'hF, 4'hF);
        apb(1'b1, ST, 32'h10FC, 4'hF);
        stall_input_active <= 1'b0;
        apb(1'b0, `OFS_IRQ_STATUS, 32'h0, 4'hF);
        pin("irq idle", 1'b0, 0);
        target_position <= 32'h0;
        pin("irq arrive", 1'b1, 0);
        apb(1'b1, ST, 32'h0, 4'hF);
        sb("arrive kept", 7, 1'b1);
        apb(1'b1, ST, 32'h80, 4'hF);
        sb("arrive clear", 7, 1'b0);
        pin("irq clear", 1'b0, 0);
        direction_reversed <= 1'b1;
        @(posedge pclk);
        direction_reversed <= 1'b0;
        sb("reverse", 12, 1'b1);
        apb(1'b1, ST, 32'h1000, 4'h1);
        sb("reverse kept", 12, 1'b1);
        apb(1'b1, ST, 32'h1000, 4'h2);
        sb("reverse clear", 12, 1'b0);
        // Stall event, then mask, unmask and irq status read
        apb(1'b1, CT, 32'h3, 4'hF);
        stall_input_active <= 1'b1;
        @(posedge pclk);
        stall_input_active <= 1'b0;
        sb("stall event", 6, 1'b1);
        pin("halt", 1'b1, 1);
        apb(1'b1, `OFS_IRQ_MASK, 32'h0, 4'hF);
        pin("irq masked", 1'b0, 0);
        apb(1'b1, `OFS_IRQ_MASK, 32'hF, 4'hF);
        pin("irq unmasked", 1'b1, 0);
        apb(1'b0, `OFS_IRQ_STATUS, 32'h0, 4'hF);
        chk("irq status", 32'hC, rd & 32'hF);
        pin("irq read", 1'b0, 0);
        apb(1'b1, ST, 32'h40, 4'hF);
        sb("stall clear", 6, 1'b0);
        pin("halt clear", 1'b0, 1);
        {virtual_stop_r, virtual_stop_l} <= 2'b11;
        @(posedge pclk);
        {virtual_stop_r, virtual_stop_l} <= 2'b00;
        apb(1'b1, ST, 32'h30, 4'hF);
        sb("stop kept", 5, 1'b1);
        pin("stop req", 1'b1, 3);
        pin("stop r req", 1'b1, 2);
        moving_negative <= 1'b1;
        sb("move away", 5, 1'b0);
        moving_negative <= 1'b0;
        apb(1'b1, CT, 32'h800, 4'hF);
        sb("hold", 4, 1'b0);
        apb(1'b1, CT, 32'h4, 4'hF);
        ref_switch_r <= 1'b1;
        sb("switch stop", 5, 1'b1);
        apb(1'b1, CT, 32'h20, 4'hF);
        sb("stop off", 5, 1'b0);
        current_position <= 32'h1234ABCD;
        ref_switch_r <= 1'b0;
        // Pin edge needs two sync stages and the edge detector
        repeat (2) @(posedge pclk);
        sb("latch r", 3, 1'b1);
        apb(1'b0, `OFS_LATCHED_POS, 32'h0, 4'hF);
        chk("latched", 32'h1234ABCD, rd);
        apb(1'b1, ST, 32'h8, 4'h1);
        sb("latch clear", 3, 1'b0);
        // Gradual stop holds the flag while still running into the stop
        apb(1'b1, CT, 32'h404, 4'hF);
        {moving_positive, virtual_stop_r} <= 2'b11;
        @(posedge pclk);
        virtual_stop_r <= 1'b0;
        apb(1'b1, CT, 32'hC04, 4'hF);
        sb("gradual kept", 5, 1'b1);
        motor_at_rest <= 1'b1;
        sb("gradual done", 5, 1'b0);
        // Left latch on the active edge
        apb(1'b1, CT, 32'h40, 4'hF);
        ref_switch_l <= 1'b1;
        repeat (2) @(posedge pclk);
        sb("latch l", 2, 1'b1);
        conclude;
    end
endmodule // ramp_status_flags_tb_top
`default_nettype wire

/* File: hw/ramp_status_flags.v */
// Ramp generator status and event flags with APB access
`timescale 1ns/1ps
`default_nettype none
`include "ramp_status_regs.vh"
module ramp_status_flags #(
    parameter PW = 32,
    parameter VW = 32
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [PW-1:0] current_position,
    input wire [PW-1:0] target_position,
    input wire [VW-1:0] current_velocity,
    input wire [VW-1:0] max_velocity,
    input wire stall_input_active,
    input wire direction_reversed,
    input wire post_halt_wait_active,
    input wire ref_switch_r,
    input wire ref_switch_l,
    input wire virtual_stop_r,
    input wire virtual_stop_l,
    input wire moving_positive,
    input wire moving_negative,
    input wire motor_at_rest,
    output reg stall_halt_request,
    output reg stop_r_request,
    output reg stop_l_request,
    output reg irq
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    wire [1:0] sw_s;
    sync2 #(.W(2)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({ref_switch_r, ref_switch_l}),
        .q(sw_s)
    );

    reg [11:0] ctl_q;
    reg [15:0] stat_q;
    reg [15:0] stat_d;
    reg [PW-1:0] latch_q;
    reg [3:0] mask_q;
    reg [3:0] irqs_q;
    reg [3:0] irqs_d;
    reg [1:0] sw_prev_q;
    reg pos_prev_q;
    reg hold_q;
    reg [1:0] stop_en_prev_q;

    // Access decode shared by write and read paths
    function hit;
        input [11:0] a;
        input [11:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    // Next stop flag of one side; the set term wins over the disable clear, hold and move away win over the set
    function stop_next;
        input cur;
        input cause;
        input toward;
        input away;
        input dis;
        input gradual;
        input at_rest;
        input hold;
        begin
            stop_next = cur;
            if (hold || away || dis)
                stop_next = 1'b0;
            // Gradual stop keeps the flag until the run has ended
            if (gradual && toward && !at_rest && cur)
                stop_next = !dis;
            if (cause && !hold && !away)
                stop_next = 1'b1;
        end
    endfunction

    wire acc = psel && penable && pready;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    wire wr_stat = wr && hit(paddr, `OFS_RAMP_STATUS) && pstrb[0];
    wire [7:0] w1c = wr_stat ? pwdata[7:0] : 8'h00;
    wire w1c_rev = wr && hit(paddr, `OFS_RAMP_STATUS) && pstrb[1]
        && pwdata[`BIT_REVERSE];

    // Active levels after polarity
    wire act_r = sw_s[1] ^ ctl_q[`CTL_POL_R];
    wire act_l = sw_s[0] ^ ctl_q[`CTL_POL_L];
    wire pos_eq = (current_position == target_position);

    // Switch edges selected for position latching
    wire rise_r = act_r && !sw_prev_q[1];
    wire fall_r = !act_r && sw_prev_q[1];
    wire rise_l = act_l && !sw_prev_q[0];
    wire fall_l = !act_l && sw_prev_q[0];
    wire latch_r_ev = (rise_r && ctl_q[`CTL_LATCH_R_ACT])
        || (fall_r && ctl_q[`CTL_LATCH_R_INACT]);
    wire latch_l_ev = (rise_l && ctl_q[`CTL_LATCH_L_ACT])
        || (fall_l && ctl_q[`CTL_LATCH_L_INACT]);

    // Disabling is an act, so a virtual stop flag survives a low enable
    wire dis_r = stop_en_prev_q[1] && !ctl_q[`CTL_STOP_R_EN];
    wire dis_l = stop_en_prev_q[0] && !ctl_q[`CTL_STOP_L_EN];

    ////////////////////////////////////////////////////////////////////////
    // Status next-state: sets win over write-1 clears
    always @*
    begin
        stat_d = stat_q;
        stat_d[`BIT_VSTOP_R] = virtual_stop_r;
        stat_d[`BIT_VSTOP_L] = virtual_stop_l;
        stat_d[`BIT_STALL] = stall_input_active
            && ctl_q[`CTL_STALL_DET];
        if (w1c_rev)
            stat_d[`BIT_REVERSE] = 1'b0;
        if (direction_reversed)
            stat_d[`BIT_REVERSE] = 1'b1;
        stat_d[`BIT_WAIT] = post_halt_wait_active;
        stat_d[`BIT_VZERO] = (current_velocity == {VW{1'b0}});
        stat_d[`BIT_POS_MATCH] = pos_eq;
        stat_d[`BIT_VEL_MATCH] = (current_velocity == max_velocity);
        // Arrival event on rising match
        if (w1c[`BIT_EV_ARRIVE])
            stat_d[`BIT_EV_ARRIVE] = 1'b0;
        if (pos_eq && !pos_prev_q)
            stat_d[`BIT_EV_ARRIVE] = 1'b1;
        // Stall halt event needs halt enabled
        if (w1c[`BIT_EV_STALL])
            stat_d[`BIT_EV_STALL] = 1'b0;
        if (stall_input_active && ctl_q[`CTL_STALL_DET]
            && ctl_q[`CTL_STALL_HALT])
            stat_d[`BIT_EV_STALL] = 1'b1;
        // Stop conditions, read-only; cleared by hardware causes
        stat_d[`BIT_EV_STOP_R] = stop_next(stat_q[`BIT_EV_STOP_R],
            (act_r && ctl_q[`CTL_STOP_R_EN]) || virtual_stop_r,
            moving_positive, moving_negative, dis_r,
            ctl_q[`CTL_GRADUAL], motor_at_rest, hold_q);
        stat_d[`BIT_EV_STOP_L] = stop_next(stat_q[`BIT_EV_STOP_L],
            (act_l && ctl_q[`CTL_STOP_L_EN]) || virtual_stop_l,
            moving_negative, moving_positive, dis_l,
            ctl_q[`CTL_GRADUAL], motor_at_rest, hold_q);
        // Latch ready flags
        if (w1c[`BIT_LATCH_R])
            stat_d[`BIT_LATCH_R] = 1'b0;
        if (latch_r_ev)
            stat_d[`BIT_LATCH_R] = 1'b1;
        if (w1c[`BIT_LATCH_L])
            stat_d[`BIT_LATCH_L] = 1'b0;
        if (latch_l_ev)
            stat_d[`BIT_LATCH_L] = 1'b1;
        stat_d[`BIT_SW_R] = act_r;
        stat_d[`BIT_SW_L] = act_l;
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status: read clears, event sets win
    always @*
    begin
        irqs_d = irqs_q;
        if (rd && hit(paddr, `OFS_IRQ_STATUS))
            irqs_d = 4'h0;
        irqs_d = irqs_d | (stat_d[7:4] & ~stat_q[7:4]);
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stat_q <= `STAT_RESET;
            ctl_q <= `CTL_RESET;
            latch_q <= {PW{1'b0}};
            mask_q <= 4'hF;
            irqs_q <= 4'h0;
            sw_prev_q <= 2'b00;
            pos_prev_q <= 1'b0;
            hold_q <= 1'b0;
            stop_en_prev_q <= 2'b00;
        end
        else
        begin
            stat_q <= stat_d;
            irqs_q <= irqs_d;
            sw_prev_q <= {act_r, act_l};
            pos_prev_q <= pos_eq;
            hold_q <= ctl_q[`CTL_HOLD];
            stop_en_prev_q <= {ctl_q[`CTL_STOP_R_EN], ctl_q[`CTL_STOP_L_EN]};
            if (latch_r_ev || latch_l_ev)
                latch_q <= current_position;
            if (wr && hit(paddr, `OFS_CONTROL))
            begin
                if (pstrb[0])
                    ctl_q[7:0] <= pwdata[7:0];
                if (pstrb[1])
                    ctl_q[11:8] <= pwdata[11:8];
            end
            if (wr && hit(paddr, `OFS_IRQ_MASK) && pstrb[0])
                mask_q <= pwdata[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, registered read data
    wire mapped = hit(paddr, `OFS_RAMP_STATUS) || hit(paddr, `OFS_LATCHED_POS)
        || hit(paddr, `OFS_CONTROL) || hit(paddr, `OFS_IRQ_MASK)
        || hit(paddr, `OFS_IRQ_STATUS);
    reg [31:0] rdata_d;
    always @*
    begin
        rdata_d = 32'h00000000;
        case (paddr)
            `OFS_RAMP_STATUS: rdata_d = {16'h0000, stat_q};
            `OFS_LATCHED_POS: rdata_d = latch_q;
            `OFS_CONTROL: rdata_d = {20'h00000, ctl_q};
            `OFS_IRQ_MASK: rdata_d = {28'h0000000, mask_q};
            `OFS_IRQ_STATUS: rdata_d = {28'h0000000, irqs_q};
            default: rdata_d = 32'h00000000;
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            // Ready drops after each access so every transfer waits once
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            if (psel && penable && !pready && !pwrite)
                prdata <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs to motion logic and interrupt line
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stall_halt_request <= 1'b0;
            stop_r_request <= 1'b0;
            stop_l_request <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            stall_halt_request <= stat_d[`BIT_EV_STALL];
            stop_r_request <= stat_d[`BIT_EV_STOP_R];
            stop_l_request <= stat_d[`BIT_EV_STOP_L];
            irq <= |(irqs_d & mask_q & stat_d[7:4]);
        end
    end
endmodule // ramp_status_flags
`default_nettype wire

/* File: hw/ramp_status_regs.vh */
// Register offsets, field positions and reset values of the ramp status block
// Summary of operation
// - Bit 13 shows stall input when enabled
// - Bit 12 sticky on reversal, write-1 clears
// - Bit 11 high during post-halt wait
// - Bit 10 high when velocity is zero
// - Bit 9 high while position equals target
// - Bit 8 high while velocity equals maximum
// - Bit 7 sticky on arrival rising edge
// - Interrupt is OR of unmasked, unread rising events of bits 7..4 still set
// - Bit 6 stall halt event, write-1 clears
// - Bits 5/4 show right/left stop conditions
// - Hold mode or move away clears stop
// - Gradual stop keeps flag until at rest
// - Disabling stop function clears stop flag
// - Bits 3/2 sticky latch ready, write-1 clears
// - Bits 1/0 show reference switch states
// - Bits 15/14 show virtual limit states
// - Switch event copies position into latch
`ifndef RAMP_STATUS_REGS_VH
`define RAMP_STATUS_REGS_VH
`define IDX_RAMP_STATUS 10'h060
`define IDX_LATCHED_POS 10'h061
`define IDX_CONTROL 10'h062
`define IDX_IRQ_MASK 10'h063
`define IDX_IRQ_STATUS 10'h064
`define OFS_RAMP_STATUS {`IDX_RAMP_STATUS, 2'b00}
`define OFS_LATCHED_POS {`IDX_LATCHED_POS, 2'b00}
`define OFS_CONTROL {`IDX_CONTROL, 2'b00}
`define OFS_IRQ_MASK {`IDX_IRQ_MASK, 2'b00}
`define OFS_IRQ_STATUS {`IDX_IRQ_STATUS, 2'b00}
`define BIT_VSTOP_R 15
`define BIT_VSTOP_L 14
`define BIT_STALL 13
`define BIT_REVERSE 12
`define BIT_WAIT 11
`define BIT_VZERO 10
`define BIT_POS_MATCH 9
`define BIT_VEL_MATCH 8
`define BIT_EV_ARRIVE 7
`define BIT_EV_STALL 6
`define BIT_EV_STOP_R 5
`define BIT_EV_STOP_L 4
`define BIT_LATCH_R 3
`define BIT_LATCH_L 2
`define BIT_SW_R 1
`define BIT_SW_L 0
`define CTL_STALL_DET 0
`define CTL_STALL_HALT 1
`define CTL_STOP_R_EN 2
`define CTL_STOP_L_EN 3
`define CTL_LATCH_R_ACT 4
`define CTL_LATCH_R_INACT 5
`define CTL_LATCH_L_ACT 6
`define CTL_LATCH_L_INACT 7
`define CTL_POL_R 8
`define CTL_POL_L 9
`define CTL_GRADUAL 10
`define CTL_HOLD 11
`define CTL_RESET 12'h000
`define STAT_RESET 16'hC000
`endif

/* File: hw/sync2.v */
// Two flip-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter W = 4
) (
    input wire pclk,
    input wire presetn,
    input wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    // First stage is read only by the second
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
        end
        else
        begin
            s1_q <= d;
            s2_q <= s1_q;
        end
    end
    assign q = s2_q;
endmodule // sync2
`default_nettype wire
